//--- pkg/rtc_pkg.sv
// Operation
// [RQ1] Address register bit 7 shows busy; writing 1 starts an indirect read.
// [RQ2] Address register bit 6 enables auto-read.
// [RQ3] Address register bit 5 reads zero; writes to it are ignored.
// [RQ4] Address register bit 4 enables the short access strobe.
// [RQ5] Address register bits 3:0 select the internal register targeted.
// [RQ6] Address field increments after each capture or alarm byte access.
// [RQ7] Data register holds the last byte transferred; resets to zero.
// [RQ8] Software avoids read-modify-write on the data register.
// [RQ9] Clock core runs from its own timebase, not the system clock.
// [RQ10] Crystal mode runs 32.768 kHz; self-oscillate spans 10 to 40 kHz.
// [RQ11] Crystal start: mode, gain off, bias double, load cap, then power.
// [RQ12] Software waits 20 ms, polls clock valid, then load-cap ready.
// [RQ13] When stable: gain on, bias double off, detector on, wait, clear wake flags.
// [RQ14] CMOS clock: lowest bias, gain off; fail flag checked 2 ms later.
// [RQ15] Self-oscillate: crystal mode cleared; bias double picks 20 or 40 kHz.
// [RQ16] Pin short control ties the two oscillator pins together internally.
// [RQ17] Software may trim self-oscillate frequency through load cap setting.
// [RQ18] Data register write starts an indirect write of that byte.
// [RQ19] With auto-read, each data register read starts the next indirect read.
// [RQ20] Access takes 7 clocks, or 6 with the short strobe.
// [RQ21] Busy stays set for the whole transfer, then clears itself.
package rtc_pkg;
	localparam logic [7:0] SFR_ADDR_CTRL  = 8'hAC;
	localparam logic [7:0] SFR_ADDR_DATA  = 8'hAD;
	localparam int         BUSY_BIT       = 7;
	localparam int         AUTO_BIT       = 6;
	localparam int         SHORT_BIT      = 4;
	localparam logic       AUTO_RESET     = 1'h0;
	localparam logic       SHORT_RESET    = 1'h1;
	localparam logic [3:0] ADDR_RESET     = 4'h0;
	localparam logic [7:0] DATA_RESET     = 8'h00;
	localparam logic [7:0] INT_RESET      = 8'h00;
	localparam logic [2:0] ACC_LONG_CYC   = 3'h7;
	localparam logic [2:0] ACC_SHORT_CYC  = 3'h6;
	localparam logic [3:0] IA_CAPTURE0    = 4'h0;
	localparam logic [3:0] IA_CAPTURE3    = 4'h3;
	localparam logic [3:0] IA_CTRL        = 4'h4;
	localparam logic [3:0] IA_OSC_CTRL    = 4'h5;
	localparam logic [3:0] IA_LOAD_CAP    = 4'h6;
	localparam logic [3:0] IA_PIN_SHORT   = 4'h7;
	localparam logic [3:0] IA_ALARM0      = 4'h8;
	localparam logic [3:0] IA_ALARM3      = 4'hB;
	localparam int         CTRL_CAPTURE   = 0;
	localparam int         CTRL_LOAD      = 1;
	localparam int         CTRL_LFO       = 2;
	localparam int         CTRL_POWER     = 7;
	localparam int         OSC_GAIN       = 7;
	localparam int         OSC_CRYSTAL_MODE_SELECT      = 6;
	localparam int         OSC_BIAS2      = 5;
	localparam int         OSC_VALID      = 4;
	localparam int         OSC_FAIL       = 2;
	localparam int         LOAD_READY     = 6;
	localparam int         PIN_SHORT      = 0;
	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} sfr_req_s;
	typedef struct packed {
		logic       crystal_mode_select;
		logic       gain_control_enable;
		logic       bias_double_enable;
		logic [3:0] load_cap_config;
		logic       oscillator_power_enable;
		logic       pin_short_control;
		logic       low_freq_oscillator;
	} osc_ctrl_s;
endpackage

//--- hw/rtc_indirect_port.sv
`timescale 1ns/1ps
module rtc_indirect_port (
	input  wire logic              clk_in,
	input  wire logic              reset_n_in,
	input  wire rtc_pkg::sfr_req_s sfr_in,
	input  wire logic              timebase_tick_in,
	input  wire logic              clock_valid_flag_in,
	input  wire logic              load_cap_ready_flag_in,
	input  wire logic              oscillator_fail_flag_in,
	output logic [7:0]             sfr_rdata_out,
	output rtc_pkg::osc_ctrl_s     osc_ctrl_out,
	output logic                   busy_out,
	output logic                   alarm_hit_out
);
	logic        busy;
	logic [2:0]  cnt;
	logic        is_wr;
	logic        auto_rd;
	logic        short_en;
	logic [3:0]  addr;
	logic [7:0]  data;
	logic [7:0]  ctrl;
	logic [7:0]  osc;
	logic [7:0]  load_cap;
	logic [7:0]  pin;
	logic [31:0] timer;
	logic [7:0]  capture [4];
	logic [7:0]  alarm [4];
	logic [7:0]  rd_mux;
	logic        wr_ctrl;
	logic        rd_ctrl;
	logic        wr_data;
	logic        rd_data;
	logic        start_rd;
	logic        start_wr;
	logic        done;
	logic        short_sel;

	function automatic logic is_multi(input logic [3:0] a);
		is_multi = (a <= rtc_pkg::IA_CAPTURE3) ||
			(a >= rtc_pkg::IA_ALARM0 && a <= rtc_pkg::IA_ALARM3);
	endfunction

	assign wr_ctrl = sfr_in.wr && sfr_in.addr == rtc_pkg::SFR_ADDR_CTRL;
	assign rd_ctrl = sfr_in.rd && sfr_in.addr == rtc_pkg::SFR_ADDR_CTRL;
	assign wr_data = sfr_in.wr && sfr_in.addr == rtc_pkg::SFR_ADDR_DATA;
	assign rd_data = sfr_in.rd && sfr_in.addr == rtc_pkg::SFR_ADDR_DATA;
	// Requests while busy are dropped so a transfer never sees its target move
	assign start_rd = !busy && ((wr_ctrl && sfr_in.wdata[rtc_pkg::BUSY_BIT]) || // RQ1
		(rd_data && auto_rd)); // RQ19
	assign start_wr = !busy && wr_data; // RQ18
	assign done = busy && cnt == 3'h0;
	// A control write that starts a read also sets the strobe length it runs with
	assign short_sel = wr_ctrl ? sfr_in.wdata[rtc_pkg::SHORT_BIT] : short_en;
	assign busy_out = busy;

	// Transfer timer
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			busy <= 1'b0;
			cnt <= 3'h0;
			is_wr <= 1'b0;
		end else if (busy) begin
			if (cnt == 3'h0) begin
				busy <= 1'b0; // RQ21
			end else begin
				cnt <= cnt - 3'h1;
			end
		end else if (start_rd || start_wr) begin
			busy <= 1'b1; // RQ21
			is_wr <= start_wr;
			cnt <= short_sel ? rtc_pkg::ACC_SHORT_CYC - 3'h1 : rtc_pkg::ACC_LONG_CYC - 3'h1; // RQ20
		end
	end

	// Address and mode fields
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			auto_rd <= rtc_pkg::AUTO_RESET;
			short_en <= rtc_pkg::SHORT_RESET;
			addr <= rtc_pkg::ADDR_RESET;
		end else if (wr_ctrl && !busy) begin
			auto_rd <= sfr_in.wdata[rtc_pkg::AUTO_BIT]; // RQ2
			short_en <= sfr_in.wdata[rtc_pkg::SHORT_BIT]; // RQ4
			addr <= sfr_in.wdata[3:0]; // RQ5
		end else if (done && is_multi(addr)) begin
			addr <= addr + 4'h1; // RQ6
		end
	end

	// Data register
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			data <= rtc_pkg::DATA_RESET; // RQ7
		end else if (start_wr) begin
			data <= sfr_in.wdata; // RQ7
		end else if (done && !is_wr) begin
			data <= rd_mux; // RQ7
		end
	end

	// Bus read data
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sfr_rdata_out <= 8'h00;
		end else if (rd_ctrl) begin
			sfr_rdata_out <= {busy, auto_rd, 1'b0, short_en, addr}; // RQ1 RQ3
		end else if (rd_data) begin
			sfr_rdata_out <= data;
		end
	end

	// Internal register read, live status merged in
	always_comb begin
		rd_mux = 8'h00;
		if (addr <= rtc_pkg::IA_CAPTURE3) begin
			rd_mux = capture[addr[1:0]];
		end else if (addr == rtc_pkg::IA_CTRL) begin
			rd_mux = ctrl;
		end else if (addr == rtc_pkg::IA_OSC_CTRL) begin
			rd_mux = osc;
			rd_mux[rtc_pkg::OSC_VALID] = clock_valid_flag_in;
			rd_mux[rtc_pkg::OSC_FAIL] = oscillator_fail_flag_in; // RQ14
		end else if (addr == rtc_pkg::IA_LOAD_CAP) begin
			rd_mux = load_cap;
			rd_mux[rtc_pkg::LOAD_READY] = load_cap_ready_flag_in;
		end else if (addr == rtc_pkg::IA_PIN_SHORT) begin
			rd_mux = pin;
		end else if (addr >= rtc_pkg::IA_ALARM0 && addr <= rtc_pkg::IA_ALARM3) begin
			rd_mux = alarm[addr[1:0]];
		end
	end

	// Oscillator setup registers
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ctrl <= rtc_pkg::INT_RESET;
			osc <= rtc_pkg::INT_RESET;
			load_cap <= rtc_pkg::INT_RESET;
			pin <= rtc_pkg::INT_RESET;
		end else if (done && is_wr) begin
			if (addr == rtc_pkg::IA_CTRL) begin
				// Capture and load are commands, never stored
				ctrl <= data & 8'hFC;
			end else if (addr == rtc_pkg::IA_OSC_CTRL) begin
				osc <= data & 8'hE0; // RQ15
			end else if (addr == rtc_pkg::IA_LOAD_CAP) begin
				load_cap <= data & 8'h0F;
			end else if (addr == rtc_pkg::IA_PIN_SHORT) begin
				pin <= data & 8'h01; // RQ16
			end
		end
	end

	assign osc_ctrl_out.crystal_mode_select = osc[rtc_pkg::OSC_CRYSTAL_MODE_SELECT]; // RQ10
	assign osc_ctrl_out.gain_control_enable = osc[rtc_pkg::OSC_GAIN];
	assign osc_ctrl_out.bias_double_enable = osc[rtc_pkg::OSC_BIAS2]; // RQ15
	assign osc_ctrl_out.load_cap_config = load_cap[3:0];
	assign osc_ctrl_out.oscillator_power_enable = ctrl[rtc_pkg::CTRL_POWER];
	assign osc_ctrl_out.pin_short_control = pin[rtc_pkg::PIN_SHORT]; // RQ16
	assign osc_ctrl_out.low_freq_oscillator = ctrl[rtc_pkg::CTRL_LFO];

	// Timer advances only on the timebase tick, never on the bus clock
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			timer <= 32'h0000_0000;
		end else if (done && is_wr && addr == rtc_pkg::IA_CTRL && data[rtc_pkg::CTRL_LOAD]) begin
			timer <= {capture[3], capture[2], capture[1], capture[0]};
		end else if (timebase_tick_in && ctrl[rtc_pkg::CTRL_POWER]) begin
			// Slow oscillator steps by two to keep crystal rate
			timer <= timer + (ctrl[rtc_pkg::CTRL_LFO] ? 32'h2 : 32'h1); // RQ9
		end
	end

	// Capture and alarm bytes
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			for (int i = 0; i < 4; i++) begin
				capture[i] <= rtc_pkg::INT_RESET;
				alarm[i] <= rtc_pkg::INT_RESET;
			end
		end else if (done && is_wr) begin
			if (addr <= rtc_pkg::IA_CAPTURE3) begin
				capture[addr[1:0]] <= data;
			end else if (addr >= rtc_pkg::IA_ALARM0 && addr <= rtc_pkg::IA_ALARM3) begin
				alarm[addr[1:0]] <= data;
			end else if (addr == rtc_pkg::IA_CTRL && data[rtc_pkg::CTRL_CAPTURE]) begin
				for (int i = 0; i < 4; i++) begin
					capture[i] <= timer[8*i +: 8];
				end
			end
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			alarm_hit_out <= 1'b0;
		end else begin
			alarm_hit_out <= ctrl[rtc_pkg::CTRL_POWER] &&
				timer == {alarm[3], alarm[2], alarm[1], alarm[0]};
		end
	end

	property p_busy_short;
		@(posedge clk_in) disable iff (!reset_n_in)
		$rose(busy) && short_en |-> busy [*6] ##1 !busy;
	endproperty
	a_busy_short: assert property (p_busy_short) else $error("short access not 6 cycles"); // RQ20

	property p_busy_long;
		@(posedge clk_in) disable iff (!reset_n_in)
		$rose(busy) && !short_en |-> busy [*7] ##1 !busy;
	endproperty
	a_busy_long: assert property (p_busy_long) else $error("long access not 7 cycles"); // RQ21

	property p_read_start;
		@(posedge clk_in) disable iff (!reset_n_in)
		wr_ctrl && !busy && sfr_in.wdata[7] |=> busy && !is_wr;
	endproperty
	a_read_start: assert property (p_read_start) else $error("busy write did not start read"); // RQ1

	property p_bit5_zero;
		@(posedge clk_in) disable iff (!reset_n_in)
		rd_ctrl |=> sfr_rdata_out[5] == 1'b0 && sfr_rdata_out[7] == $past(busy);
	endproperty
	a_bit5_zero: assert property (p_bit5_zero) else $error("control readback wrong"); // RQ3

	property p_fields;
		@(posedge clk_in) disable iff (!reset_n_in)
		wr_ctrl && !busy |=> addr == $past(sfr_in.wdata[3:0]) &&
			auto_rd == $past(sfr_in.wdata[6]) && short_en == $past(sfr_in.wdata[4]);
	endproperty
	a_fields: assert property (p_fields) else $error("control fields not stored"); // RQ5

	property p_write_start;
		@(posedge clk_in) disable iff (!reset_n_in)
		wr_data && !busy |=> busy && is_wr && data == $past(sfr_in.wdata);
	endproperty
	a_write_start: assert property (p_write_start) else $error("data write did not start"); // RQ18

	property p_autoread;
		@(posedge clk_in) disable iff (!reset_n_in)
		rd_data && auto_rd && !busy |=> busy && !is_wr;
	endproperty
	a_autoread: assert property (p_autoread) else $error("auto-read not started"); // RQ19

	property p_incr;
		@(posedge clk_in) disable iff (!reset_n_in)
		done && is_multi(addr) |=> addr == $past(addr) + 4'h1;
	endproperty
	a_incr: assert property (p_incr) else $error("address did not increment"); // RQ6

	property p_read_data;
		@(posedge clk_in) disable iff (!reset_n_in)
		done && !is_wr |=> data == $past(rd_mux);
	endproperty
	a_read_data: assert property (p_read_data) else $error("read byte not captured"); // RQ7

	property p_busy_clear;
		@(posedge clk_in) disable iff (!reset_n_in)
		done |=> !busy;
	endproperty
	a_busy_clear: assert property (p_busy_clear) else $error("busy did not clear at end of access"); // RQ21

	property p_ctrl_refused;
		@(posedge clk_in) disable iff (!reset_n_in)
		wr_ctrl && busy && !done |=> $stable(addr) && $stable(auto_rd) && $stable(short_en);
	endproperty
	a_ctrl_refused: assert property (p_ctrl_refused) else $error("control write taken while busy"); // RQ5

	property p_data_refused;
		@(posedge clk_in) disable iff (!reset_n_in)
		wr_data && busy && !done |=> $stable(data) && busy;
	endproperty
	a_data_refused: assert property (p_data_refused) else $error("data write taken while busy"); // RQ18

	property p_no_incr;
		@(posedge clk_in) disable iff (!reset_n_in)
		done && !is_multi(addr) |=> $stable(addr);
	endproperty
	a_no_incr: assert property (p_no_incr) else $error("address moved on a single register"); // RQ6

	property p_auto_off;
		@(posedge clk_in) disable iff (!reset_n_in)
		rd_data && !auto_rd && !busy |=> !busy;
	endproperty
	a_auto_off: assert property (p_auto_off) else $error("read started with auto-read off"); // RQ2

	property p_rdata_data;
		@(posedge clk_in) disable iff (!reset_n_in)
		rd_data |=> sfr_rdata_out == $past(data);
	endproperty
	a_rdata_data: assert property (p_rdata_data) else $error("data register readback wrong"); // RQ7

	property p_osc_write;
		@(posedge clk_in) disable iff (!reset_n_in)
		done && is_wr && addr == rtc_pkg::IA_OSC_CTRL |=> osc == ($past(data) & 8'hE0);
	endproperty
	a_osc_write: assert property (p_osc_write) else $error("oscillator control not stored"); // RQ15

	property p_pin_write;
		@(posedge clk_in) disable iff (!reset_n_in)
		done && is_wr && addr == rtc_pkg::IA_PIN_SHORT |=> pin == ($past(data) & 8'h01);
	endproperty
	a_pin_write: assert property (p_pin_write) else $error("pin short not stored"); // RQ16

	property p_timer_hold;
		@(posedge clk_in) disable iff (!reset_n_in)
		!timebase_tick_in && !(done && is_wr) |=> $stable(timer);
	endproperty
	a_timer_hold: assert property (p_timer_hold) else $error("timer moved without a tick"); // RQ9
endmodule

//--- dv/rtc_osc_model.sv
`timescale 1ns/1ps
module rtc_osc_model #(
	parameter int TICK_DIV    = 8,
	parameter int VALID_TICKS = 4
) (
	input  wire logic               clk_in,
	input  wire logic               reset_n_in,
	input  wire rtc_pkg::osc_ctrl_s osc_ctrl_in,
	output logic                    tick_out,
	output logic                    valid_out,
	output logic                    ready_out,
	output logic                    fail_out
);
	// Shortened period stands in for the slow timebase
	int div;
	int ticks;
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			div <= 0;
			ticks <= 0;
			tick_out <= 1'b0;
		end else if (osc_ctrl_in.oscillator_power_enable) begin
			div <= (div == TICK_DIV - 1) ? 0 : div + 1;
			tick_out <= (div == TICK_DIV - 1);
			if (div == TICK_DIV - 1 && ticks < 255)
				ticks <= ticks + 1;
		end else begin
			div <= 0;
			ticks <= 0;
			tick_out <= 1'b0;
		end
	end
	// Valid only meaningful for a crystal; load settles after it
	assign valid_out = osc_ctrl_in.crystal_mode_select && ticks >= VALID_TICKS;
	assign ready_out = valid_out && ticks >= 2 * VALID_TICKS;
	assign fail_out  = !osc_ctrl_in.oscillator_power_enable;
endmodule

//--- dv/tb_rtc_indirect_port.sv
`timescale 1ns/1ps
module tb_rtc_indirect_port;
	logic               clk_in     = 1'b0;
	logic               reset_n_in = 1'b0;
	rtc_pkg::sfr_req_s  sfr        = '0;
	logic               tick;
	logic               valid;
	logic               ready;
	logic               fail;
	logic [7:0]         rdata;
	rtc_pkg::osc_ctrl_s osc;
	logic               busy;
	logic               alarm_hit;
	int                 bad_count  = 0;
	int                 n_tests    = 0;
	int                 n;
	logic [3:0]         a;
	// Rows: internal address, byte written, byte read back
	logic [19:0]        rows [6]   = '{20'h7FF01, 20'h48080, 20'h60505, 20'h85A5A, 20'h9A5A5, 20'hBC3C3};

	always #20 clk_in = ~clk_in;

	rtc_indirect_port i_rtc_indirect_port (.clk_in(clk_in), .reset_n_in(reset_n_in), .sfr_in(sfr),
		.timebase_tick_in(tick), .clock_valid_flag_in(valid), .load_cap_ready_flag_in(ready),
		.oscillator_fail_flag_in(fail), .sfr_rdata_out(rdata), .osc_ctrl_out(osc), .busy_out(busy),
		.alarm_hit_out(alarm_hit));
	rtc_osc_model i_rtc_osc_model (.clk_in(clk_in), .reset_n_in(reset_n_in), .osc_ctrl_in(osc),
		.tick_out(tick), .valid_out(valid), .ready_out(ready), .fail_out(fail));

	task automatic test_done;
		$display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One-cycle strobe; qualifiers held until the taking edge
	task automatic bus(input logic w, input logic [7:0] ad, input logic [7:0] d);
		@(posedge clk_in);
		#1;
		sfr.addr = ad;
		sfr.wr = w;
		// Plain reads and writes only, never read-modify-write
		sfr.rd = !w;
		sfr.wdata = d;
		@(posedge clk_in);
		#1;
		sfr.wr = 1'b0;
		sfr.rd = 1'b0;
	endtask

	task automatic rd(input logic [7:0] ad, input logic [7:0] exp, input string name);
		bus(1'b0, ad, 8'h00);
		@(posedge clk_in);
		#1;
		check(name, rdata, exp);
	endtask

	task automatic wait_idle;
		@(posedge clk_in);
		#1;
		for (int i = 0; i < 20; i++) begin
			if (busy === 1'b0)
				return;
			@(posedge clk_in);
			#1;
		end
		bad_count++;
		$display("CHECK FAILED busy expected 0 seen 1");
		test_done();
	endtask

	task automatic count_busy(output int c);
		c = 0;
		for (int i = 0; i < 20; i++) begin
			if (busy === 1'b1)
				c++;
			else if (c > 0)
				break;
			@(posedge clk_in);
			#1;
		end
	endtask

	task automatic iwr(input logic [3:0] ia, input logic [7:0] d);
		bus(1'b1, 8'hAC, {4'h1, ia});
		bus(1'b1, 8'hAD, d);
		wait_idle();
	endtask

	task automatic ird(input logic [3:0] ia);
		bus(1'b1, 8'hAC, {4'h9, ia});
		wait_idle();
		bus(1'b0, 8'hAD, 8'h00);
	endtask

	task automatic poll(input logic [3:0] ia, input int b, input string name);
		for (int i = 0; i < 20; i++) begin
			ird(ia);
			if (rdata[b] === 1'b1)
				break;
		end
		check(name, {7'h00, rdata[b]}, 8'h01);
		if (rdata[b] !== 1'b1)
			test_done();
	endtask

	function automatic logic [7:0] osc_bits();
		osc_bits = {4'h0, osc.crystal_mode_select, osc.gain_control_enable, osc.bias_double_enable,
			osc.oscillator_power_enable};
	endfunction

	initial begin
		repeat (8) @(posedge clk_in);
		#1;
		reset_n_in = 1'b1;
		rd(8'hAC, 8'h10, "ctrl reset");
		rd(8'hAD, 8'h00, "data reset");
		bus(1'b1, 8'hAC, 8'h35);
		rd(8'hAC, 8'h15, "unused bit");
		$display("Test reset done");
		foreach (rows[k]) begin
			a = rows[k][19:16];
			bus(1'b1, 8'hAC, {4'h1, a});
			bus(1'b1, 8'hAD, rows[k][15:8]);
			wait_idle();
			rd(8'hAC, {4'h1, a + ((a < 4'h4 || (a >= 4'h8 && a <= 4'hB)) ? 4'h1 : 4'h0)}, "addr step");
			bus(1'b1, 8'hAC, {4'h9, a});
			wait_idle();
			rd(8'hAD, rows[k][7:0], "readback");
		end
		check("pin short", {7'h00, osc.pin_short_control}, 8'h01);
		check("load cap", {4'h0, osc.load_cap_config}, 8'h05);
		$display("Test table done");
		bus(1'b1, 8'hAC, 8'h18);
		bus(1'b1, 8'hAD, 8'h11);
		count_busy(n);
		check("short busy", 8'(n), 8'h06);
		bus(1'b1, 8'hAC, 8'h08);
		bus(1'b1, 8'hAD, 8'h22);
		count_busy(n);
		check("long busy", 8'(n), 8'h07);
		// Second write and a control write land while busy and must be dropped
		bus(1'b1, 8'hAD, 8'h44);
		bus(1'b1, 8'hAD, 8'h55);
		bus(1'b1, 8'hAC, 8'hFF);
		wait_idle();
		rd(8'hAD, 8'h44, "refused write");
		rd(8'hAC, 8'h0A, "single step");
		$display("Test timing done");
		bus(1'b1, 8'hAC, 8'hD8);
		wait_idle();
		rd(8'hAD, 8'h22, "auto first");
		wait_idle();
		rd(8'hAD, 8'h44, "auto next");
		wait_idle();
		rd(8'hAE, 8'h44, "unmapped");
		$display("Test auto read done");
		iwr(4'h4, 8'h00);
		ird(4'h5);
		check("fail flag", rdata, 8'h04);
		iwr(4'h5, 8'h40);
		iwr(4'h5, 8'h60);
		iwr(4'h6, 8'h07);
		iwr(4'h4, 8'h80);
		check("osc start", osc_bits(), 8'h0B);
		// Settling time is scaled down in the model
		poll(4'h5, rtc_pkg::OSC_VALID, "clock valid");
		poll(4'h6, rtc_pkg::LOAD_READY, "load ready");
		check("load cap ready", rdata, 8'h47);
		// Detector and wake flags live outside this block
		iwr(4'h5, 8'hC0);
		check("osc run", osc_bits(), 8'h0D);
		iwr(4'h5, 8'h20);
		ird(4'h5);
		check("self osc", rdata, 8'h20);
		check("self osc out", osc_bits(), 8'h03);
		iwr(4'h4, 8'h84);
		check("slow osc", {7'h00, osc.low_freq_oscillator}, 8'h01);
		$display("Test oscillator done");
		for (int i = 0; i < 4; i++) begin
			iwr(4'(i), 8'h31 + 8'(i));
			iwr(4'h8 + 4'(i), 8'h31 + 8'(i));
		end
		iwr(4'h4, 8'h02);
		iwr(4'h0, 8'h00);
		iwr(4'h4, 8'h01);
		ird(4'h0);
		check("capture", rdata, 8'h31);
		check("alarm unpowered", {7'h00, alarm_hit}, 8'h00);
		iwr(4'h4, 8'h80);
		@(posedge clk_in);
		#1;
		check("alarm hit", {7'h00, alarm_hit}, 8'h01);
		repeat (12) @(posedge clk_in);
		#1;
		check("alarm passed", {7'h00, alarm_hit}, 8'h00);
		$display("Test alarm done");
		reset_n_in = 1'b0;
		@(posedge clk_in);
		#1;
		reset_n_in = 1'b1;
		rd(8'hAD, 8'h00, "data after reset");
		rd(8'hAC, 8'h10, "ctrl after reset");
		$display("Test second reset done");
		test_done();
	end
endmodule
